// File: core/astc_pkg.sv
// constants, field layouts and carrier types of the sample trigger control
// assumes one 125 MHz clock and an AXI4-Lite master on the register side
package astc_pkg;

  localparam int          ADDR_W         = 8;
  localparam logic [7:0]  CTRL_ONE_OFF   = 8'h00;
  localparam logic [7:0]  CONFIG_OFF     = 8'h04;
  localparam logic [7:0]  STATUS_OFF     = 8'h08;

  localparam int          SRC_SEL_POS    = 5;
  localparam int          GROUP_POS      = 4;
  localparam int          SIMUL_POS      = 3;
  localparam int          AUTO_START_POS = 2;
  localparam int          SAMPLE_POS     = 1;
  localparam int          DONE_POS       = 0;
  localparam int          TWELVE_POS     = 2;
  localparam int          CONV_POS       = 6;
  localparam int          SEQ_POS        = 4;

  localparam logic [2:0]  SRC_SEL_RST    = 3'h0;
  localparam logic [1:0]  CHAN_CNT_RST   = 2'h0;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  localparam int          CLK_PERIOD_PS  = 8000;
  localparam int          CONV_TIME_NS   = 1000;
  localparam int          AUTO_TRIG_NS   = 248;
  localparam int          CONV_CYCLES    =
    (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          AUTO_TRIG_CYC  =
    (AUTO_TRIG_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          TRIG_W         = 13;

  typedef struct packed {
    logic [2:0] pwm_gen_pri;
    logic [3:0] pattern_gen_out;
    logic       charge_time_unit;
    logic       pwm_sec_special;
    logic       pwm_pri_special;
    logic       timer_five;
    logic       timer_three;
    logic       ext_interrupt_pin_zero;
  } astc_trig_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } astc_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } astc_axi_rsp_t;

endpackage

// File: core/astc_edge.sv
// rising edge detector for a vector of trigger levels
// assumes inputs synchronous to the clock
`timescale 1ns/1ps
module astc_edge #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  input  wire logic [W-1:0] i_level,
  output logic      [W-1:0] o_rise
);

  logic [W-1:0] prev;
  logic [W-1:0] next_prev;

  always_comb begin
    next_prev = i_level;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      prev <= '0;
    end else begin
      prev <= next_prev;
    end
  end

  assign o_rise = i_level & ~prev;

endmodule

// File: core/astc_top.sv
// sample and conversion sequencing with AXI4-Lite control registers
// assumes trigger inputs synchronous to I_CLK; one write and one read in flight
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module astc_top
  import astc_pkg::*;
(
  input  wire logic          I_CLK,
  input  wire logic          I_RESET,
  input  wire astc_axi_req_t I_AXI,
  output astc_axi_rsp_t      O_AXI,
  input  wire astc_trig_t    I_TRIG,
  output logic               O_SAMPLE_ACTIVE,
  output logic               O_CONV_START,
  output logic               O_CONVERTING,
  output logic               O_DONE,
  output logic [3:0]         O_SH_SAMPLE
);

  typedef struct packed {
    logic [2:0]        src_sel;
    logic              group;
    logic              simul;
    logic              auto_start;
    logic              sample;
    logic              done;
    logic [1:0]        chan_cnt;
    logic              twelve;
    logic              converting;
    logic [9:0]        conv_cnt;
    logic [7:0]        sample_cnt;
    logic [1:0]        seq_chan;
    logic              conv_start;
    logic [3:0]        sh_sample;
    logic              aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_full;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    astc_axi_rsp_t     rsp;
  } astc_state_t;

  astc_state_t        st;
  astc_state_t        next_st;
  logic [TRIG_W-1:0]  trig_rise;
  astc_trig_t         te;
  logic               sim_eff;
  logic [1:0]         chan_mask;
  logic [9:0]         conv_total;
  logic               sel_trig;
  logic               auto_done;

  astc_edge #(
    .W (TRIG_W)
  ) u_edge (
    .i_clk   (I_CLK),
    .i_reset (I_RESET),
    .i_level (I_TRIG),
    .o_rise  (trig_rise)
  );

  assign te = trig_rise;

  // simultaneous select only counts with two or four channels
  assign sim_eff = st.simul & ~st.twelve & (st.chan_cnt != 2'h0);

  // channel index mask: 1, 2 or 4 channels
  always_comb begin
    unique case (st.chan_cnt)
      2'h0:    chan_mask = 2'h0;
      2'h1:    chan_mask = 2'h1;
      default: chan_mask = 2'h3;
    endcase
  end

  // simultaneous converts every channel; sequence converts one per conversion
  always_comb begin
    conv_total = 10'(CONV_CYCLES);
    if (sim_eff) begin
      conv_total = 10'(CONV_CYCLES * (int'(chan_mask) + 1));
    end
  end

  assign auto_done = (st.sample_cnt == 8'(AUTO_TRIG_CYC - 1));

  // trigger that ends sampling and starts conversion
  always_comb begin
    sel_trig = 1'b0;
    if (st.group) begin
      unique case (st.src_sel)
        3'h7: sel_trig = 1'b0;
        3'h6: sel_trig = te.pattern_gen_out[3];
        3'h5: sel_trig = te.pattern_gen_out[2];
        3'h4: sel_trig = te.pattern_gen_out[1];
        3'h3: sel_trig = te.pattern_gen_out[0];
        3'h2: sel_trig = te.pwm_gen_pri[2];
        3'h1: sel_trig = te.pwm_gen_pri[1];
        3'h0: sel_trig = te.pwm_gen_pri[0];
      endcase
    end else begin
      unique case (st.src_sel)
        3'h7: sel_trig = auto_done;
        3'h6: sel_trig = te.charge_time_unit;
        3'h5: sel_trig = te.pwm_sec_special;
        3'h4: sel_trig = te.timer_five;
        3'h3: sel_trig = te.pwm_pri_special;
        3'h2: sel_trig = te.timer_three;
        3'h1: sel_trig = te.ext_interrupt_pin_zero;
        3'h0: sel_trig = 1'b0;
      endcase
    end
  end

  always_comb begin
    logic        wr_go;
    logic        hit;
    logic        manual;
    logic        sw_end;
    logic        done_clr;
    logic        start_conv;
    logic [31:0] rd;
    wr_go      = 1'b0;
    hit        = 1'b0;
    manual     = ~st.group & (st.src_sel == 3'h0);
    sw_end     = 1'b0;
    done_clr   = 1'b0;
    start_conv = 1'b0;
    rd         = 32'h0;
    next_st    = st;
    next_st.conv_start = 1'b0;

    // write channel: address and data taken in either order
    if (I_AXI.awvalid && st.rsp.awready) begin
      next_st.aw_full = 1'b1;
      next_st.aw_addr = I_AXI.awaddr;
    end
    if (I_AXI.wvalid && st.rsp.wready) begin
      next_st.w_full = 1'b1;
      next_st.wdata  = I_AXI.wdata;
      next_st.wstrb  = I_AXI.wstrb;
    end
    if (st.rsp.bvalid && I_AXI.bready) begin
      next_st.rsp.bvalid = 1'b0;
    end
    wr_go = next_st.aw_full & next_st.w_full & ~st.rsp.bvalid;

    if (wr_go) begin
      hit = 1'b1;
      unique case (next_st.aw_addr)
        CTRL_ONE_OFF: begin
          if (next_st.wstrb[0]) begin
            next_st.src_sel    = next_st.wdata[SRC_SEL_POS +: 3];
            next_st.group      = next_st.wdata[GROUP_POS];
            next_st.simul      = next_st.wdata[SIMUL_POS];
            next_st.auto_start = next_st.wdata[AUTO_START_POS];
            if (next_st.wdata[SAMPLE_POS]) begin
              if (!st.converting) begin
                next_st.sample = 1'b1;
              end
            end else if (st.sample && manual && !st.converting) begin
              sw_end = 1'b1;
            end
            if (!next_st.wdata[DONE_POS]) begin
              done_clr = 1'b1;
            end
          end
        end
        CONFIG_OFF: begin
          if (next_st.wstrb[0]) begin
            next_st.chan_cnt = next_st.wdata[1:0];
            next_st.twelve   = next_st.wdata[TWELVE_POS];
          end
        end
        STATUS_OFF: begin
          hit = 1'b1;
        end
        default: begin
          hit = 1'b0;
        end
      endcase
      next_st.aw_full    = 1'b0;
      next_st.w_full     = 1'b0;
      next_st.rsp.bvalid = 1'b1;
      next_st.rsp.bresp  = hit ? RESP_OKAY : RESP_SLVERR;
    end
    next_st.rsp.awready = ~next_st.aw_full & ~next_st.rsp.bvalid;
    next_st.rsp.wready  = ~next_st.w_full & ~next_st.rsp.bvalid;

    // read channel
    if (st.rsp.rvalid && I_AXI.rready) begin
      next_st.rsp.rvalid = 1'b0;
    end
    if (I_AXI.arvalid && st.rsp.arready) begin
      hit = 1'b1;
      unique case (I_AXI.araddr)
        CTRL_ONE_OFF: begin
          rd[SRC_SEL_POS +: 3] = st.src_sel;
          rd[GROUP_POS]        = st.group;
          rd[SIMUL_POS]        = st.simul & ~st.twelve;
          rd[AUTO_START_POS]   = st.auto_start;
          rd[SAMPLE_POS]       = st.sample;
          rd[DONE_POS]      = st.done;
        end
        CONFIG_OFF: begin
          rd[1:0]        = st.chan_cnt;
          rd[TWELVE_POS] = st.twelve;
        end
        STATUS_OFF: begin
          rd[3:0]            = st.sh_sample;
          rd[SEQ_POS +: 2]   = st.seq_chan;
          rd[CONV_POS]       = st.converting;
        end
        default: begin
          hit = 1'b0;
        end
      endcase
      next_st.rsp.rvalid = 1'b1;
      next_st.rsp.rdata  = rd;
      next_st.rsp.rresp  = hit ? RESP_OKAY : RESP_SLVERR;
    end
    next_st.rsp.arready = ~next_st.rsp.rvalid;

    // software clear first so a completion in the same cycle wins
    if (done_clr) begin
      next_st.done = 1'b0;
    end

    start_conv = sw_end | (st.sample & ~st.converting & sel_trig);
    if (start_conv) begin
      next_st.sample     = 1'b0;
      next_st.converting = 1'b1;
      next_st.conv_cnt   = 10'h0;
      next_st.done       = 1'b0;
      next_st.conv_start = 1'b1;
    end else if (st.converting) begin
      if (st.conv_cnt == conv_total - 10'h1) begin
        next_st.converting = 1'b0;
        next_st.done       = 1'b1;
        if (!sim_eff) begin
          next_st.seq_chan = (st.seq_chan + 2'h1) & chan_mask;
        end
      end else begin
        next_st.conv_cnt = st.conv_cnt + 10'h1;
      end
    end else if (next_st.auto_start && !next_st.sample) begin
      next_st.sample = 1'b1;
    end

    // internal sample timer runs only while sampling continues
    if (st.sample && next_st.sample && !auto_done) begin
      next_st.sample_cnt = st.sample_cnt + 8'h1;
    end else if (!next_st.sample) begin
      next_st.sample_cnt = 8'h0;
    end

    // sample-and-hold channels that track while sampling
    next_st.sh_sample = 4'h0;
    if (next_st.sample) begin
      if (sim_eff) begin
        next_st.sh_sample = (chan_mask == 2'h1) ? 4'h3 : 4'hf;
      end else begin
        next_st.sh_sample = 4'h1 << (next_st.seq_chan & chan_mask);
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      st                 <= '0;
      st.src_sel         <= SRC_SEL_RST;
      st.chan_cnt        <= CHAN_CNT_RST;
      st.rsp.awready     <= 1'b1;
      st.rsp.wready      <= 1'b1;
      st.rsp.arready     <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign O_AXI           = st.rsp;
  assign O_SAMPLE_ACTIVE = st.sample;
  assign O_CONV_START    = st.conv_start;
  assign O_CONVERTING    = st.converting;
  assign O_DONE          = st.done;
  assign O_SH_SAMPLE     = st.sh_sample;

endmodule

// File: tb/astc_checker.sv
// port checks of the sample trigger control
// assumes bound to astc_top, one clock, synchronous reset
`timescale 1ns/1ps
module astc_checker
  import astc_pkg::*;
(
  input wire logic          I_CLK,
  input wire logic          I_RESET,
  input wire astc_axi_req_t I_AXI,
  input wire astc_axi_rsp_t O_AXI,
  input wire astc_trig_t    I_TRIG,
  input wire logic          O_SAMPLE_ACTIVE,
  input wire logic          O_CONV_START,
  input wire logic          O_CONVERTING,
  input wire logic          O_DONE,
  input wire logic [3:0]    O_SH_SAMPLE
);
  int cnt;
  // length of the current conversion
  always_ff @(posedge I_CLK) begin
    if (I_RESET || !O_CONVERTING) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RESET);
  chk_start_pulse: assert property (
    O_CONV_START |=> !O_CONV_START && O_CONVERTING)
    else $error("start pulse wrong");
  chk_start_cause: assert property (
    O_CONV_START |-> $past(O_SAMPLE_ACTIVE) && !$past(O_CONVERTING)
      && !O_SAMPLE_ACTIVE)
    else $error("start without sampling");
  chk_start_clear: assert property (
    $rose(O_CONVERTING) |-> O_CONV_START && !O_DONE)
    else $error("done not cleared at start");
  chk_done_low: assert property (
    O_CONVERTING |-> !O_DONE)
    else $error("done during conversion");
  chk_done_cause: assert property (
    $rose(O_DONE) |-> $fell(O_CONVERTING))
    else $error("done set without completion");
  chk_conv_len: assert property (
    $fell(O_CONVERTING) && !$past(I_RESET) |-> O_DONE
      && (cnt == CONV_CYCLES || cnt == 2 * CONV_CYCLES
      || cnt == 4 * CONV_CYCLES))
    else $error("conversion length wrong");
  chk_hold_sh: assert property (
    !O_SAMPLE_ACTIVE |-> O_SH_SAMPLE == 4'h0)
    else $error("tracking while holding");
  chk_conv_quiet: assert property (
    $rose(O_SAMPLE_ACTIVE) |-> O_SH_SAMPLE != 4'h0 && !O_CONVERTING)
    else $error("sampling start wrong");
endmodule

bind astc_top astc_checker i_chk (.I_CLK(I_CLK), .I_RESET(I_RESET),
  .I_AXI(I_AXI), .O_AXI(O_AXI), .I_TRIG(I_TRIG),
  .O_SAMPLE_ACTIVE(O_SAMPLE_ACTIVE), .O_CONV_START(O_CONV_START),
  .O_CONVERTING(O_CONVERTING), .O_DONE(O_DONE), .O_SH_SAMPLE(O_SH_SAMPLE));

// File: tb/astc_trig_src.sv
// trigger source model: raises requested levels for three cycles
// assumes requests synchronous to i_clk, promptly or after 5 cycles
`timescale 1ns/1ps
module astc_trig_src
  import astc_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic [12:0] i_fire,
  input  wire logic        i_slow,
  output astc_trig_t       o_trig
);
  logic [12:0] pend = 13'h0;
  logic [2:0]  dly = 3'h0;
  logic [1:0]  hold = 2'h0;
  initial o_trig = '0;
  always @(posedge i_clk) begin
    if (i_fire != 13'h0) begin
      pend <= i_fire;
      dly <= i_slow ? 3'h5 : 3'h0;
    end else if (pend != 13'h0) begin
      if (dly == 3'h0) begin
        o_trig <= astc_trig_t'(pend);
        pend <= 13'h0;
        hold <= 2'h2;
      end else begin
        dly <= dly - 3'h1;
      end
    end else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end else begin
      o_trig <= '0;
    end
  end
endmodule

// File: tb/adc_sample_trigger_control_bench.sv
// register level tests of the sample trigger control
// assumes astc_top with the checker bound to it
`timescale 1ns/1ps
module adc_sample_trigger_control_bench
  import astc_pkg::*;
();
  logic clk, rst, sampling, cst, conv, done, slow;
  logic [3:0] sh;
  logic [12:0] fire;
  logic [31:0] rv;
  logic [1:0] rp;
  astc_axi_req_t ax;
  astc_axi_rsp_t rs;
  astc_trig_t trig;
  int miscompares, tests_run;
  logic [7:0] tbl [13] = '{8'he9, 8'hd8, 8'hc7, 8'hb6, 8'hac, 8'h9b,
    8'h8a, 8'h65, 8'h54, 8'h42, 8'h33, 8'h21, 8'h10};
  astc_top i_dut (.I_CLK(clk), .I_RESET(rst), .I_AXI(ax), .O_AXI(rs),
    .I_TRIG(trig), .O_SAMPLE_ACTIVE(sampling), .O_CONV_START(cst),
    .O_CONVERTING(conv), .O_DONE(done), .O_SH_SAMPLE(sh));
  astc_trig_src i_src (.i_clk(clk), .i_fire(fire), .i_slow(slow),
    .o_trig(trig));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ra, rw, rb;
    rb = 1'b0;
    @(posedge clk);
    ax.awvalid <= 1'b1;
    ax.awaddr <= a;
    ax.wvalid <= 1'b1;
    ax.wdata <= d;
    ax.bready <= 1'b1;
    while (!rb) begin
      @(negedge clk);
      ra = ax.awvalid & rs.awready;
      rw = ax.wvalid & rs.wready;
      rb = rs.bvalid;
      rp = rs.bresp;
      @(posedge clk);
      if (ra) ax.awvalid <= 1'b0;
      if (rw) ax.wvalid <= 1'b0;
    end
    ax.bready <= 1'b0;
    // let the outputs settle before the caller looks at them
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta, rr;
    rr = 1'b0;
    @(posedge clk);
    ax.arvalid <= 1'b1;
    ax.araddr <= a;
    ax.rready <= 1'b1;
    while (!rr) begin
      @(negedge clk);
      ta = ax.arvalid & rs.arready;
      rr = rs.rvalid;
      rv = rs.rdata;
      rp = rs.rresp;
      @(posedge clk);
      if (ta) ax.arvalid <= 1'b0;
    end
    ax.rready <= 1'b0;
  endtask
  task automatic pulse(input logic [12:0] b, input logic s);
    @(posedge clk);
    fire <= b;
    slow <= s;
    @(posedge clk);
    fire <= 13'h0;
  endtask
  // wait for a start pulse (d=0) or the done flag (d=1)
  task automatic wt(input bit d, input int n);
    int k;
    k = 0;
    while ((d ? done : cst) !== 1'b1 && k < n) begin
      @(negedge clk);
      k++;
    end
    cmp(d ? done : cst, 1'b1);
  endtask
  task automatic conclude;
    if (miscompares == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #400000;
    miscompares++;
    conclude();
  end
  initial begin
    rst = 1'b1;
    ax = '0;
    ax.wstrb = 4'h1;
    fire = 13'h0;
    slow = 1'b0;
    miscompares = 0;
    tests_run = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(8'h00);
    cmp(rv, 32'h0);
    rd(8'h0c);
    cmp(rp, RESP_SLVERR);
    wr(8'h0c, 32'h0);
    cmp(rp, RESP_SLVERR);
    // manual sampling and conversion
    wr(8'h00, 32'h2);
    cmp({sampling, sh}, 5'h11);
    cmp(rp, RESP_OKAY);
    wr(8'h00, 32'h0);
    @(negedge clk);
    cmp({conv, sampling}, 2'h2);
    wt(1, 600);
    rd(8'h00);
    cmp(rv, 32'h1);
    wr(8'h00, 32'h2);
    cmp({done, sampling}, 2'h1);
    wr(8'h00, 32'h3);
    cmp(done, 1'b0);
    wr(8'h00, 32'h1);
    wt(1, 600);
    // every trigger input of both groups, then unused group one code 7
    foreach (tbl[i]) begin
      wr(8'h00, {24'h0, tbl[i][6:4], tbl[i][7], 4'h3});
      pulse(~(13'h1 << tbl[i][3:0]), 1'b0);
      repeat (8) @(negedge clk);
      cmp(sampling, 1'b1);
      pulse(13'h1 << tbl[i][3:0], i[0]);
      wt(0, 20);
      cmp({done, sampling}, 2'h0);
      wt(1, 600);
    end
    wr(8'h00, 32'hf3);
    pulse(13'h1fff, 1'b0);
    repeat (40) @(negedge clk);
    cmp({sampling, conv}, 2'h2);
    // internal counter with auto-start
    wr(8'h00, 32'he7);
    wt(0, 40);
    wt(1, 600);
    @(negedge clk);
    @(negedge clk);
    cmp(sampling, 1'b1);
    wt(0, 40);
    wr(8'h00, 32'he3);
    wt(1, 600);
    // simultaneous sampling by channel count
    wr(8'h04, 32'h2);
    wr(8'h00, 32'h0b);
    cmp(sh, 4'hf);
    wr(8'h00, 32'h09);
    wt(1, 600);
    wr(8'h04, 32'h1);
    wr(8'h00, 32'h0b);
    cmp(sh, 4'h3);
    wr(8'h00, 32'h09);
    wt(1, 600);
    wr(8'h04, 32'h6);
    rd(8'h04);
    cmp(rv, 32'h6);
    wr(8'h00, 32'h0b);
    rd(8'h00);
    cmp(rv[3], 1'b0);
    cmp(sh, 4'h1);
    rd(8'h08);
    cmp(rv, 32'h01);
    wr(8'h00, 32'h01);
    wt(1, 600);
    // sequential mode moves on to the next channel
    wr(8'h00, 32'h03);
    cmp(sh, 4'h2);
    rd(8'h08);
    cmp(rv, 32'h12);
    wr(8'h00, 32'h01);
    wt(1, 600);
    conclude();
  end
endmodule
